// ### logic/mcp_pkg.sv
package mcp_pkg;

  // ----------------------------------------------------------------
  // Register map (APB byte addresses)
  // ----------------------------------------------------------------
  localparam int          MCP_ADDR_W     = 8;
  localparam logic [7:0]  MCP_OFS_CTRL   = 8'h00;
  localparam logic [7:0]  MCP_OFS_STATUS = 8'h04;
  localparam logic [7:0]  MCP_OFS_MASK   = 8'h08;
  localparam logic [7:0]  MCP_OFS_STATE  = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MCP_CTRL_HP_EN    = 0;
  localparam int MCP_CTRL_LOS_MODE = 1;
  localparam int MCP_EV_DONE       = 0;
  localparam int MCP_EV_FAULT      = 1;
  localparam int MCP_EV_LOS        = 2;
  localparam int MCP_NUM_EV        = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] MCP_MASK_RST   = 3'h7;
  localparam logic [2:0] MCP_STATUS_RST = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCP_CLK_NS       = 10;
  localparam int MCP_RESET_MIN_NS = 10_000;
  localparam int MCP_INIT_NS      = 1_000;
  // Least time rounds up
  localparam int MCP_RESET_MIN_CYC = (MCP_RESET_MIN_NS + MCP_CLK_NS - 1) / MCP_CLK_NS;
  localparam int MCP_INIT_CYC      = (MCP_INIT_NS + MCP_CLK_NS - 1) / MCP_CLK_NS;
  localparam int MCP_CNT_W         = 16;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MCP_ST_HELD  = 3'b001,
    MCP_ST_INIT  = 3'b010,
    MCP_ST_READY = 3'b100
  } mcp_fsm_type;

  typedef struct packed {
    mcp_fsm_type           state;
    logic [MCP_CNT_W-1:0]  cnt;
    logic [MCP_CNT_W-1:0]  rcnt;
    logic                  dnr;
    logic                  hp_en;
    logic                  los_mode;
    logic [MCP_NUM_EV-1:0] status;
    logic [MCP_NUM_EV-1:0] mask;
    logic                  init_sel;
    logic                  selected;
    logic                  rx_los;
    logic                  sda_oe;
    logic                  hp_out;
    logic                  int_oe;
    logic                  irq;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
  } mcp_state_type;

  localparam mcp_state_type MCP_STATE_RST = '{
    state: MCP_ST_INIT, cnt: '0, rcnt: '0, dnr: 1'b1, hp_en: 1'b0,
    los_mode: 1'b0, status: MCP_STATUS_RST, mask: MCP_MASK_RST,
    init_sel: 1'b1, selected: 1'b0, rx_los: 1'b0, sda_oe: 1'b0,
    hp_out: 1'b0, int_oe: 1'b0, irq: 1'b0, pready: 1'b0,
    pslverr: 1'b0, prdata: 32'h0000_0000};

endpackage

// ### logic/mcp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_sync #(
  parameter int         WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             MCLK_I,
  input  wire logic             SRST_I,
  input  wire logic             CE_I,
  input  wire logic [WIDTH-1:0] ASYNC_I,
  output logic      [WIDTH-1:0] SYNC_O
);

  logic [WIDTH-1:0] meta_ff;

  // First stage is read by the second stage only
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      meta_ff <= RST_VAL;
      SYNC_O  <= RST_VAL;
    end else if (CE_I) begin
      meta_ff <= ASYNC_I;
      SYNC_O  <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ### logic/mcp_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_top
  import mcp_pkg::*;
#(
  parameter int RESET_MIN_CYC = MCP_RESET_MIN_CYC,
  parameter int INIT_CYC      = MCP_INIT_CYC
) (
  input  wire logic                  MCLK_I,
  input  wire logic                  SRST_I,
  input  wire logic                  CE_I,
  // APB slave
  input  wire logic                  PSEL_I,
  input  wire logic                  PENABLE_I,
  input  wire logic                  PWRITE_I,
  input  wire logic [MCP_ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]           PWDATA_I,
  output logic      [31:0]           PRDATA_O,
  output logic                       PREADY_O,
  output logic                       PSLVERR_O,
  output logic                       IRQ_O,
  // Module pins
  input  wire logic                  MODULE_SELECT_N_I,
  input  wire logic                  MODULE_RESET_N_I,
  input  wire logic                  INIT_CONTROL_SELECT_I,
  output logic                       MODULE_PRESENT_N_O,
  output logic                       MODULE_PRESENT_N_OE_O,
  output logic                       INTERRUPT_N_O,
  output logic                       INTERRUPT_N_OE_O,
  // Serial data gate toward the 2-wire engine
  input  wire logic                  SDA_PULL_I,
  output logic                       SDA_O,
  output logic                       SDA_OE_O,
  output logic                       TWI_SELECTED_O,
  // Module-internal status
  input  wire logic                  RX_LOSS_OF_SIGNAL_N_I,
  input  wire logic                  FAULT_I,
  output logic                       HIGH_POWER_O,
  output logic                       DATA_NOT_READY_O
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (RESET_MIN_CYC < 1 || RESET_MIN_CYC >= (1 << MCP_CNT_W) - 1) begin : g_chk_rst
    $error("RESET_MIN_CYC out of range");
  end
  if (INIT_CYC < 1 || INIT_CYC >= (1 << MCP_CNT_W)) begin : g_chk_init
    $error("INIT_CYC out of range");
  end

  localparam logic [MCP_CNT_W-1:0] RST_LIM  = MCP_CNT_W'(RESET_MIN_CYC);
  localparam logic [MCP_CNT_W-1:0] INIT_LST = MCP_CNT_W'(INIT_CYC - 1);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       sel_n_s;
  logic       reset_n_s;
  logic       init_s;

  // Select and reset idle high; init-mode idles high as if pulled up
  mcp_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h7)
  ) u_sync (
    .MCLK_I  (MCLK_I),
    .SRST_I  (SRST_I),
    .CE_I    (CE_I),
    .ASYNC_I ({MODULE_SELECT_N_I, MODULE_RESET_N_I, INIT_CONTROL_SELECT_I}),
    .SYNC_O  (pins_s)
  );

  assign sel_n_s   = pins_s[2];
  assign reset_n_s = pins_s[1];
  assign init_s    = pins_s[0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  mcp_state_type         st_ff;
  mcp_state_type         nxt_st;
  logic                  access;
  logic                  mapped;
  logic [MCP_NUM_EV-1:0] ev_set;
  logic [MCP_NUM_EV-1:0] ev_clr;

  always_comb begin
    nxt_st = st_ff;
    ev_set = '0;
    ev_clr = '0;
    access = PSEL_I && PENABLE_I && st_ff.pready;
    mapped = (PADDR_I == MCP_OFS_CTRL) || (PADDR_I == MCP_OFS_STATUS) ||
             (PADDR_I == MCP_OFS_MASK) || (PADDR_I == MCP_OFS_STATE);

    nxt_st.selected = !sel_n_s;
    nxt_st.init_sel = init_s;
    nxt_st.rx_los   = !RX_LOSS_OF_SIGNAL_N_I;

    // Register writes take effect at the completing edge
    if (access && PWRITE_I) begin
      case (PADDR_I)
        MCP_OFS_CTRL: begin
          nxt_st.hp_en    = PWDATA_I[MCP_CTRL_HP_EN];
          nxt_st.los_mode = PWDATA_I[MCP_CTRL_LOS_MODE];
        end
        MCP_OFS_STATUS: ev_clr = PWDATA_I[MCP_NUM_EV-1:0];
        MCP_OFS_MASK:   nxt_st.mask = PWDATA_I[MCP_NUM_EV-1:0];
        default: ;
      endcase
    end

    // Reset pin filter: only a pulse lasting at least the minimum acts
    if (reset_n_s) begin
      nxt_st.rcnt = '0;
    end else if (st_ff.rcnt != RST_LIM) begin
      nxt_st.rcnt = st_ff.rcnt + MCP_CNT_W'(1);
    end

    case (st_ff.state)
      MCP_ST_HELD: begin
        nxt_st.dnr = 1'b1;
        if (reset_n_s) begin
          nxt_st.state = MCP_ST_INIT;
          nxt_st.cnt   = '0;
        end
      end
      MCP_ST_INIT: begin
        if (st_ff.cnt == INIT_LST) begin
          nxt_st.state       = MCP_ST_READY;
          nxt_st.dnr         = 1'b0;
          ev_set[MCP_EV_DONE] = 1'b1;
        end else begin
          nxt_st.cnt = st_ff.cnt + MCP_CNT_W'(1);
        end
      end
      MCP_ST_READY: ;
      default: nxt_st.state = MCP_ST_HELD;
    endcase

    ev_set[MCP_EV_FAULT] = FAULT_I;
    ev_set[MCP_EV_LOS]   = nxt_st.rx_los != st_ff.rx_los;
    // A new event wins over a clear in the same cycle
    nxt_st.status = (st_ff.status & ~ev_clr) | ev_set;

    // Full reset after a long pulse: all settings back to defaults
    if (!reset_n_s && nxt_st.rcnt == RST_LIM && st_ff.rcnt != RST_LIM) begin
      nxt_st.state    = MCP_ST_HELD;
      nxt_st.cnt      = '0;
      nxt_st.dnr      = 1'b1;
      nxt_st.hp_en    = 1'b0;
      nxt_st.los_mode = 1'b0;
      nxt_st.mask     = MCP_MASK_RST;
      nxt_st.status   = MCP_STATUS_RST;
    end

    // APB answer: one wait cycle, data captured with ready
    nxt_st.pready = PSEL_I && PENABLE_I && !st_ff.pready;
    if (nxt_st.pready) begin
      nxt_st.pslverr = !mapped;
      nxt_st.prdata  = 32'h0000_0000;
      if (!PWRITE_I) begin
        case (PADDR_I)
          MCP_OFS_CTRL: begin
            nxt_st.prdata[MCP_CTRL_HP_EN]    = st_ff.hp_en;
            nxt_st.prdata[MCP_CTRL_LOS_MODE] = st_ff.los_mode;
          end
          MCP_OFS_STATUS: nxt_st.prdata[MCP_NUM_EV-1:0] = st_ff.status;
          MCP_OFS_MASK:   nxt_st.prdata[MCP_NUM_EV-1:0] = st_ff.mask;
          MCP_OFS_STATE:  nxt_st.prdata[7:0] = {st_ff.state, st_ff.rx_los, st_ff.selected,
                                                st_ff.init_sel, st_ff.hp_out, st_ff.dnr};
          default: ;
        endcase
      end
    end else begin
      nxt_st.pslverr = 1'b0;
      nxt_st.prdata  = 32'h0000_0000;
    end

    // Outputs are computed from next state so they stay consistent with it
    nxt_st.sda_oe = nxt_st.selected && SDA_PULL_I;
    nxt_st.hp_out = (nxt_st.state == MCP_ST_READY) &&
                    (!nxt_st.init_sel || nxt_st.hp_en);
    nxt_st.irq    = |(nxt_st.status & nxt_st.mask);
    nxt_st.int_oe = nxt_st.los_mode ? nxt_st.rx_los : nxt_st.irq;
  end

  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      st_ff <= MCP_STATE_RST;
    end else if (CE_I) begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign PRDATA_O              = st_ff.prdata;
  assign PREADY_O              = st_ff.pready;
  assign PSLVERR_O             = st_ff.pslverr;
  assign IRQ_O                 = st_ff.irq;
  // Presence is a constant ground path while the module is inserted
  assign MODULE_PRESENT_N_O    = 1'b0;
  assign MODULE_PRESENT_N_OE_O = 1'b1;
  // Open drain: never drive high, release instead
  assign INTERRUPT_N_O         = 1'b0;
  assign INTERRUPT_N_OE_O      = st_ff.int_oe;
  assign SDA_O                 = 1'b0;
  assign SDA_OE_O              = st_ff.sda_oe;
  assign TWI_SELECTED_O        = st_ff.selected;
  assign HIGH_POWER_O          = st_ff.hp_out;
  assign DATA_NOT_READY_O      = st_ff.dnr;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  sequence s_rst_done;
    st_ff.state == MCP_ST_HELD && reset_n_s && CE_I;
  endsequence

  sequence s_init_last;
    st_ff.state == MCP_ST_INIT && st_ff.cnt == INIT_LST && CE_I;
  endsequence

  a_sda_gate_sel: assert property (SDA_OE_O |-> TWI_SELECTED_O)
    else $error("data line driven while unselected");
  a_sda_unsel_rel: assert property (!st_ff.selected |-> !SDA_OE_O)
    else $error("data line not released");
  a_reset_long_pulse: assert property (
      CE_I && !reset_n_s && st_ff.rcnt == RST_LIM - MCP_CNT_W'(1)
      |=> st_ff.state == MCP_ST_HELD && !st_ff.hp_en && st_ff.dnr)
    else $error("long reset pulse did not restore defaults");
  a_reset_leave: assert property (s_rst_done |=> st_ff.state == MCP_ST_INIT)
    else $error("reset release did not start init");
  a_done_posted: assert property (
      s_init_last |=> st_ff.status[MCP_EV_DONE] && !DATA_NOT_READY_O)
    else $error("completion not posted");
  a_done_int_pin: assert property (
      s_init_last ##1 (st_ff.mask[MCP_EV_DONE] && !st_ff.los_mode)
      |-> INTERRUPT_N_OE_O)
    else $error("interrupt pin not asserted on completion");
  a_power_up_init: assert property ($past(SRST_I) |-> st_ff.state == MCP_ST_INIT)
    else $error("power-up did not start init");
  a_init_pullup: assert property ($past(SRST_I) |-> st_ff.init_sel)
    else $error("init-mode default not high");
  a_low_power_hold: assert property (
      HIGH_POWER_O && st_ff.init_sel |-> st_ff.hp_en)
    else $error("high power without software enable");
  a_hw_init_power: assert property (
      st_ff.state == MCP_ST_READY && !st_ff.init_sel |-> HIGH_POWER_O)
    else $error("hardware init did not enter high power");
  a_present_ground: assert property (
      MODULE_PRESENT_N_OE_O && !MODULE_PRESENT_N_O)
    else $error("presence line not grounded");
  a_int_status: assert property (
      !st_ff.los_mode |-> INTERRUPT_N_OE_O == |(st_ff.status & st_ff.mask))
    else $error("interrupt pin disagrees with status");
  a_int_open_drain: assert property (!INTERRUPT_N_O)
    else $error("interrupt pin driven high");
  a_los_mode_pin: assert property (
      st_ff.los_mode |-> INTERRUPT_N_OE_O == st_ff.rx_los)
    else $error("loss-of-signal mode wrong");

endmodule
`default_nettype wire

// ### verif/mcp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_host_model (
  input  wire logic interrupt_n_i,
  input  wire logic interrupt_n_oe_i,
  input  wire logic module_present_n_i,
  input  wire logic module_present_n_oe_i,
  input  wire logic init_drive_i,
  input  wire logic init_level_i,
  output logic      interrupt_n_o,
  output logic      module_present_n_o,
  output logic      init_control_select_o
);
  // Board pull-ups: a released line reads high
  assign interrupt_n_o         = interrupt_n_oe_i ? interrupt_n_i : 1'h1;
  assign module_present_n_o    = module_present_n_oe_i ? module_present_n_i : 1'h1;
  // Undriven pin settles at the module pull-up; the bench only drives it across a reset
  assign init_control_select_o = init_drive_i ? init_level_i : 1'h1;
  // Single module on this bus, so its select line is private to it
endmodule
`default_nettype wire

// ### verif/mcp_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcp_top_test
  import mcp_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} mcp_row_type;
  logic        mclk, srst, psel, penable, pwrite, sel_n, rst_n, drv, lvl, pull, los_n, fault, ce, sda;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, irq, prs, prs_oe, int_n, int_oe, sda_oe, twi_sel, hp, dnr, e;
  logic        int_pin, prs_pin, init_pin;
  int          n_errors, tests_run;
  mcp_row_type rows [8] = '{
    '{1'h1, MCP_OFS_MASK, 32'h0000_0005, 32'h0000_0000, 1'h0},
    '{1'h0, MCP_OFS_MASK, 32'h0000_0000, 32'h0000_0005, 1'h0},
    '{1'h1, MCP_OFS_MASK, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0},
    '{1'h0, MCP_OFS_MASK, 32'h0000_0000, 32'h0000_0007, 1'h0},
    '{1'h1, MCP_OFS_STATE, 32'hFFFF_FFFF, 32'h0000_0000, 1'h0},
    '{1'h0, MCP_OFS_CTRL, 32'h0000_0000, 32'h0000_0000, 1'h0},
    '{1'h0, 8'h10, 32'h0000_0000, 32'h0000_0000, 1'h1},
    '{1'h1, 8'h10, 32'h0000_0003, 32'h0000_0000, 1'h1}};

  mcp_top #(.RESET_MIN_CYC(4), .INIT_CYC(4)) mcp_top_i (
    .MCLK_I(mclk), .SRST_I(srst), .CE_I(ce), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IRQ_O(irq), .MODULE_SELECT_N_I(sel_n), .MODULE_RESET_N_I(rst_n),
    .INIT_CONTROL_SELECT_I(init_pin), .MODULE_PRESENT_N_O(prs), .MODULE_PRESENT_N_OE_O(prs_oe),
    .INTERRUPT_N_O(int_n), .INTERRUPT_N_OE_O(int_oe), .SDA_PULL_I(pull), .SDA_O(sda),
    .SDA_OE_O(sda_oe), .TWI_SELECTED_O(twi_sel), .RX_LOSS_OF_SIGNAL_N_I(los_n),
    .FAULT_I(fault), .HIGH_POWER_O(hp), .DATA_NOT_READY_O(dnr));

  mcp_host_model mcp_host_model_i (
    .interrupt_n_i(int_n), .interrupt_n_oe_i(int_oe), .module_present_n_i(prs),
    .module_present_n_oe_i(prs_oe), .init_drive_i(drv), .init_level_i(lvl),
    .interrupt_n_o(int_pin), .module_present_n_o(prs_pin), .init_control_select_o(init_pin));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic fail(input string m);
    n_errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] x, input string m);
    tests_run++;
    if (g !== x) fail(m);
  endtask
  task automatic chk_bit(input logic g, input logic x, input string m);
    tests_run++;
    if (g !== x) fail(m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Master waits for ready with no assumed latency, bounded only by a guard
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) fail("no ready");
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'h0, a, 32'h0000_0000);
    chk_word(q, x, "read data");
  endtask
  // Status bits are not trusted until the block reports itself ready
  task automatic wait_done();
    int n;
    n = 0;
    while (dnr !== 1'h0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk_bit(dnr, 1'h0, "not ready");
    cyc(2);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20_000) @(posedge mclk);
    n_errors++;
    close_out();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, drv, lvl, fault} = '0;
    {srst, sel_n, rst_n, pull, los_n, ce} = 6'h3F;
    n_errors = 0;
    tests_run = 0;
    cyc(16);
    srst <= 1'h0;
    wait_done();
    chk_bit(irq, 1'h1, "power-up irq");
    chk_bit(int_pin, 1'h0, "power-up pin");
    chk_bit(prs_pin, 1'h0, "presence");
    rd(MCP_OFS_STATUS, 32'h0000_0001);
    rd(MCP_OFS_STATE, 32'h0000_0084);
    chk_bit(hp, 1'h0, "low power");
    done("powerup");
    for (int i = 0; i < 8; i++) begin
      bus(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk_word(q, rows[i].x, "row data");
      chk_bit(e, rows[i].e, "row error");
    end
    done("rows");
    bus(1'h1, MCP_OFS_STATUS, 32'h0000_0001);
    cyc(2);
    chk_bit(int_pin, 1'h1, "released");
    fault <= 1'h1;
    cyc(1);
    fault <= 1'h0;
    cyc(3);
    chk_bit(int_pin, 1'h0, "fault pin");
    rd(MCP_OFS_STATUS, 32'h0000_0002);
    bus(1'h1, MCP_OFS_MASK, 32'h0000_0005);
    cyc(2);
    chk_bit(irq, 1'h0, "masked");
    chk_bit(int_pin, 1'h1, "masked pin");
    bus(1'h1, MCP_OFS_STATUS, 32'h0000_0002);
    bus(1'h1, MCP_OFS_MASK, 32'h0000_0007);
    bus(1'h1, MCP_OFS_CTRL, 32'h0000_0001);
    cyc(2);
    chk_bit(hp, 1'h1, "software high power");
    done("interrupt");
    chk_bit(sda_oe, 1'h0, "sda unselected");
    chk_bit(twi_sel, 1'h0, "engine off");
    sel_n <= 1'h0;
    cyc(5);
    chk_bit(twi_sel, 1'h1, "engine on");
    chk_bit(sda_oe, 1'h1, "sda selected");
    chk_bit(sda, 1'h0, "sda pulls low only");
    pull <= 1'h0;
    cyc(3);
    chk_bit(sda_oe, 1'h0, "sda follows engine");
    pull <= 1'h1;
    sel_n <= 1'h1;
    cyc(5);
    chk_bit(sda_oe, 1'h0, "sda deselected");
    done("select");
    // Events arriving while the clock enable is low must be lost, not queued
    ce    <= 1'h0;
    fault <= 1'h1;
    cyc(2);
    fault <= 1'h0;
    ce    <= 1'h1;
    cyc(2);
    chk_bit(irq, 1'h0, "frozen while disabled");
    rd(MCP_OFS_STATUS, 32'h0000_0000);
    done("enable");
    bus(1'h1, MCP_OFS_CTRL, 32'h0000_0002);
    los_n <= 1'h0;
    cyc(5);
    chk_bit(int_pin, 1'h0, "los low");
    los_n <= 1'h1;
    cyc(5);
    chk_bit(int_pin, 1'h1, "los high");
    bus(1'h1, MCP_OFS_CTRL, 32'h0000_0003);
    bus(1'h1, MCP_OFS_STATUS, 32'h0000_0007);
    done("los");
    bus(1'h1, MCP_OFS_MASK, 32'h0000_0003);
    rst_n <= 1'h0;
    cyc(2);
    rst_n <= 1'h1;
    cyc(6);
    rd(MCP_OFS_CTRL, 32'h0000_0003);
    rst_n <= 1'h0;
    cyc(10);
    chk_bit(dnr, 1'h1, "held");
    rst_n <= 1'h1;
    wait_done();
    rd(MCP_OFS_CTRL, 32'h0000_0000);
    rd(MCP_OFS_MASK, 32'h0000_0007);
    rd(MCP_OFS_STATUS, 32'h0000_0001);
    chk_bit(int_pin, 1'h0, "reset done pin");
    done("pin reset");
    // Init level only changes while the block is held, as on a fresh insertion
    srst <= 1'h1;
    drv  <= 1'h1;
    cyc(4);
    srst <= 1'h0;
    wait_done();
    chk_bit(hp, 1'h1, "hardware high power");
    done("hardware init");
    close_out();
  end
endmodule
`default_nettype wire
